// file: inc/vic_pkg.sv
// Purpose: shared constants for the virtual cpu interface control block
// Assumes: word-aligned byte offsets on the documented register port
// Notes: offsets are byte addresses within the virtual interface space
package vic_pkg;
	localparam int unsigned VIC_ADDR_W = 13;
	localparam int unsigned VIC_DATA_W = 32;
	localparam int unsigned VIC_ID_W = 10;
	localparam int unsigned VIC_BP_W = 3;

	// register offsets
	localparam logic [12:0] VIC_OFS_CONTROL = 13'h0000;
	localparam logic [12:0] VIC_OFS_ACK = 13'h000C;
	localparam logic [12:0] VIC_OFS_EOI = 13'h0010;
	localparam logic [12:0] VIC_OFS_ALIAS_ACK = 13'h0020;
	localparam logic [12:0] VIC_OFS_ALIAS_EOI = 13'h0024;
	localparam logic [12:0] VIC_OFS_DEACTIVATE = 13'h1000;

	// control register fields
	localparam int unsigned VIC_BIT_GRP0_EN = 0;
	localparam int unsigned VIC_BIT_GRP1_EN = 1;
	localparam int unsigned VIC_BIT_ACK_CONTROL = 2;
	localparam int unsigned VIC_BIT_FAST_SEL = 3;
	localparam int unsigned VIC_BIT_COMMON_BP = 4;
	localparam int unsigned VIC_BIT_SPLIT = 9;
	localparam logic [31:0] VIC_CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] VIC_CONTROL_MASK = 32'h0000_021F;

	// interrupt ids answered by the acknowledge registers
	localparam logic [9:0] VIC_ID_GRP1_HIDDEN = 10'h03FE;
	localparam logic [9:0] VIC_ID_SPURIOUS = 10'h03FF;

	// what a completion request does to the list registers
	typedef enum logic [1:0]
	{
		VIC_OP_NONE = 2'b00,
		VIC_OP_DROP = 2'b01,
		VIC_OP_DROP_DEACT = 2'b10,
		VIC_OP_DEACT = 2'b11
	} vic_op_t;
endpackage

// file: inc/vic_done_if.sv
// Purpose: carries completion and acknowledge requests to the sequencer
// Assumes: one clock; requests are single-cycle strobes
// Notes: op and id are meaningful only while a strobe is high
interface vic_done_if;
	import vic_pkg::*;
	vic_op_t op;
	logic ack;
	logic [VIC_ID_W-1:0] id;
	modport ctl (output op, output ack, output id);
	modport seq (input op, input ack, input id);
endinterface

// file: src/vic_completion.sv
// Purpose: turns completion requests into list register and distributor strobes
// Assumes: at most one request per cycle from the control logic
// Notes: every output is registered, one cycle after the request
module vic_completion
	import vic_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// requests
	vic_done_if.seq req,
	// list register updates
	output logic o_lr_drop,
	output logic o_lr_deact,
	output logic o_lr_ack,
	output logic [VIC_ID_W-1:0] o_lr_id,
	// distributor completion
	output logic o_dist_done,
	output logic [VIC_ID_W-1:0] o_dist_id
);
	wire drop_w = (req.op == VIC_OP_DROP) || (req.op == VIC_OP_DROP_DEACT);
	wire deact_w = (req.op == VIC_OP_DEACT) || (req.op == VIC_OP_DROP_DEACT);
	wire any_w = drop_w || deact_w || req.ack;

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_lr_drop <= 1'b0;
			o_lr_deact <= 1'b0;
			o_lr_ack <= 1'b0;
			o_dist_done <= 1'b0;
			o_lr_id <= '0;
			o_dist_id <= '0;
		end
		else
		begin
			o_lr_drop <= drop_w;
			o_lr_deact <= deact_w;
			o_lr_ack <= req.ack;
			o_dist_done <= deact_w;
			if (any_w)
				o_lr_id <= req.id;
			if (deact_w)
				o_dist_id <= req.id;
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);

	// the distributor only ever hears of an interrupt that was deactivated
	a_done_with_deact: assert property (o_dist_done |-> o_lr_deact && o_dist_id == o_lr_id)
		else $error("distributor completion without list register deactivation");
	a_drop_follows_op: assert property (drop_w |=> o_lr_drop && o_lr_id == $past(req.id))
		else $error("priority drop not forwarded with its id");
	a_ack_not_complete: assert property (req.ack && req.op == VIC_OP_NONE |=> !o_dist_done)
		else $error("acknowledge raised a completion");
endmodule

// file: src/vic_control.sv
// Purpose: control register and end-of-interrupt steering of a virtual cpu interface
// Assumes: register port and list register view are synchronous to i_clock
// Notes: binary point values and list register storage live outside this block
import vic_pkg::*;

// What this block does
// - combined mode: end write drops and deactivates
// - combined end write updates entry, notifies distributor
// - split mode: end write only drops priority
// - split end write records drop in entry
// - split deactivate write deactivates, notifies distributor
// - common point clear: separate points per group
// - common point set: main point for both
// - fast select presents group 0 as fast
// - ack control clear: group 1 reads 1022 at the ack register
// - ack control set: group 1 acknowledged
// - group 1 enable gates group 1 signalling
// - group 0 enable gates group 0 signalling
// - disabled group acknowledge reads return spurious
// - group taken from list entry group bit
// - control at offset zero, resets zero
module vic_control
	import vic_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// register port
	input wire logic i_reg_sel,
	input wire logic i_reg_write,
	input wire logic [VIC_ADDR_W-1:0] i_reg_addr,
	input wire logic [VIC_DATA_W-1:0] i_reg_wdata,
	output logic o_reg_rvalid,
	output logic [VIC_DATA_W-1:0] o_reg_rdata,
	// highest pending virtual interrupt from the list registers
	input wire logic i_hp_valid,
	input wire logic i_hp_group1,
	input wire logic [VIC_ID_W-1:0] i_hp_id,
	// binary point values held elsewhere
	input wire logic [VIC_BP_W-1:0] i_binary_point,
	input wire logic [VIC_BP_W-1:0] i_aliased_binary_point,
	output logic [VIC_BP_W-1:0] o_grp0_binary_point,
	output logic [VIC_BP_W-1:0] o_grp1_binary_point,
	// signalling to the virtual machine
	output logic o_virtual_irq,
	output logic o_fast_interrupt_request,
	// list register updates
	output logic o_lr_drop,
	output logic o_lr_deact,
	output logic o_lr_ack,
	output logic [VIC_ID_W-1:0] o_lr_id,
	// distributor completion
	output logic o_dist_done,
	output logic [VIC_ID_W-1:0] o_dist_id
);
	function automatic logic [VIC_DATA_W-1:0] widen_id(input logic [VIC_ID_W-1:0] id);
		widen_id = {{(VIC_DATA_W-VIC_ID_W){1'b0}}, id};
	endfunction

	logic [VIC_DATA_W-1:0] control_q;
	logic [VIC_DATA_W-1:0] control_d;
	logic [VIC_DATA_W-1:0] rdata_d;
	logic irq_d;
	logic fast_req_d;

	// address decode
	wire rd_w = i_reg_sel && !i_reg_write;
	wire wr_w = i_reg_sel && i_reg_write;
	wire hit_control = (i_reg_addr == VIC_OFS_CONTROL);
	wire hit_ack = (i_reg_addr == VIC_OFS_ACK);
	wire hit_eoi = (i_reg_addr == VIC_OFS_EOI);
	wire hit_alias_ack = (i_reg_addr == VIC_OFS_ALIAS_ACK);
	wire hit_alias_eoi = (i_reg_addr == VIC_OFS_ALIAS_EOI);
	wire hit_deact = (i_reg_addr == VIC_OFS_DEACTIVATE);

	// control fields
	wire grp0_en = control_q[VIC_BIT_GRP0_EN];
	wire grp1_en = control_q[VIC_BIT_GRP1_EN];
	wire group1_ack_control = control_q[VIC_BIT_ACK_CONTROL];
	wire fast_sel = control_q[VIC_BIT_FAST_SEL];
	wire common_bp = control_q[VIC_BIT_COMMON_BP];
	wire split_mode = control_q[VIC_BIT_SPLIT];

	// group of the pending interrupt comes from its list entry
	wire hp_grp1 = i_hp_valid && i_hp_group1;
	wire hp_grp0 = i_hp_valid && !i_hp_group1;
	wire hp_on = (hp_grp0 && grp0_en) || (hp_grp1 && grp1_en);

	// acknowledge register answer
	wire ack_takes = (hp_grp0 && grp0_en) || (hp_grp1 && grp1_en && group1_ack_control);
	wire ack_hidden = hp_grp1 && grp1_en && !group1_ack_control;
	wire [VIC_ID_W-1:0] ack_id = ack_takes ? i_hp_id
		: ack_hidden ? VIC_ID_GRP1_HIDDEN
		: VIC_ID_SPURIOUS;

	// aliased acknowledge answers group 1 only
	wire alias_takes = hp_grp1 && grp1_en;
	wire [VIC_ID_W-1:0] alias_id = alias_takes ? i_hp_id : VIC_ID_SPURIOUS;

	wire take_ack = rd_w && ((hit_ack && ack_takes) || (hit_alias_ack && alias_takes));

	// completion requests
	wire eoi_w = wr_w && (hit_eoi || hit_alias_eoi);
	// a deactivate write in combined mode has no defined effect, so it is dropped
	wire deact_w = wr_w && hit_deact && split_mode;
	wire [VIC_ID_W-1:0] wr_id = i_reg_wdata[VIC_ID_W-1:0];

	vic_done_if done_bus();

	assign done_bus.op = (eoi_w && !split_mode) ? VIC_OP_DROP_DEACT
		: eoi_w ? VIC_OP_DROP
		: deact_w ? VIC_OP_DEACT
		: VIC_OP_NONE;
	assign done_bus.ack = take_ack;
	assign done_bus.id = take_ack ? (hit_ack ? i_hp_id : alias_id) : wr_id;

	vic_completion u_completion
	(
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.req(done_bus.seq),
		.o_lr_drop(o_lr_drop),
		.o_lr_deact(o_lr_deact),
		.o_lr_ack(o_lr_ack),
		.o_lr_id(o_lr_id),
		.o_dist_done(o_dist_done),
		.o_dist_id(o_dist_id)
	);

	// control register write, reserved bits discarded
	assign control_d = (wr_w && hit_control) ? (i_reg_wdata & VIC_CONTROL_MASK) : control_q;

	// read mux; unmapped and write-only offsets read as zero
	always_comb
	begin
		rdata_d = '0;
		if (hit_control)
			rdata_d = control_q;
		else if (hit_ack)
			rdata_d = widen_id(ack_id);
		else if (hit_alias_ack)
			rdata_d = widen_id(alias_id);
	end

	// signalling: group 1 is always a normal request
	assign fast_req_d = hp_on && hp_grp0 && fast_sel;
	assign irq_d = hp_on && !(hp_grp0 && fast_sel);

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			control_q <= VIC_CONTROL_RESET;
		else
			control_q <= control_d;
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_reg_rvalid <= 1'b0;
			o_reg_rdata <= '0;
		end
		else
		begin
			o_reg_rvalid <= rd_w;
			if (rd_w)
				o_reg_rdata <= rdata_d;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_virtual_irq <= 1'b0;
			o_fast_interrupt_request <= 1'b0;
		end
		else
		begin
			o_virtual_irq <= irq_d;
			o_fast_interrupt_request <= fast_req_d;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_grp0_binary_point <= '0;
			o_grp1_binary_point <= '0;
		end
		else
		begin
			o_grp0_binary_point <= i_binary_point;
			o_grp1_binary_point <= common_bp ? i_binary_point : i_aliased_binary_point;
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);

	sequence s_eoi_combined;
		eoi_w && !split_mode;
	endsequence

	sequence s_eoi_split;
		eoi_w && split_mode;
	endsequence

	sequence s_dir_write;
		wr_w && hit_deact;
	endsequence

	sequence s_read_ack;
		rd_w && hit_ack;
	endsequence

	a_combined_eoi_both: assert property (s_eoi_combined |=> o_lr_drop && o_lr_deact)
		else $error("combined end write did not drop and deactivate");
	a_combined_eoi_done: assert property (s_eoi_combined |=>
		o_dist_done && o_dist_id == $past(wr_id))
		else $error("combined end write did not notify distributor");
	a_combined_dir_void: assert property (s_dir_write ##0 !split_mode |=> !o_lr_deact)
		else $error("deactivate write acted in combined mode");
	a_split_eoi_drop: assert property (s_eoi_split |=> o_lr_drop && !o_lr_deact && !o_dist_done)
		else $error("split end write did more than drop priority");
	a_split_dir_done: assert property (s_dir_write ##0 split_mode |=>
		o_lr_deact && o_dist_done && o_lr_id == $past(wr_id))
		else $error("split deactivate write not completed");
	a_split_bp: assert property (!common_bp |=>
		o_grp1_binary_point == $past(i_aliased_binary_point))
		else $error("group 1 point not from aliased register");
	a_common_bp: assert property (common_bp |=>
		o_grp1_binary_point == $past(i_binary_point)
		&& o_grp0_binary_point == $past(i_binary_point))
		else $error("common point not applied to both groups");
	a_fast_select: assert property (hp_grp0 && grp0_en |=>
		o_fast_interrupt_request == $past(fast_sel) && o_virtual_irq == !$past(fast_sel))
		else $error("group 0 presented on wrong request line");
	a_grp1_hidden: assert property (s_read_ack ##0 ack_hidden |=>
		o_reg_rvalid && o_reg_rdata == widen_id(VIC_ID_GRP1_HIDDEN) && !o_lr_ack)
		else $error("hidden group 1 read not answered with 1022");
	a_grp1_acked: assert property (s_read_ack ##0 hp_grp1 && grp1_en && group1_ack_control |=>
		o_lr_ack && o_reg_rdata == widen_id($past(i_hp_id)))
		else $error("group 1 not acknowledged with ack control set");
	a_grp1_blocked: assert property (hp_grp1 && !grp1_en |=> !o_virtual_irq)
		else $error("disabled group 1 still signalled");
	a_grp0_blocked: assert property (hp_grp0 && !grp0_en |=>
		!o_virtual_irq && !o_fast_interrupt_request)
		else $error("disabled group 0 still signalled");
	a_disabled_spurious: assert property (rd_w && hit_alias_ack && hp_grp1 && !grp1_en |=>
		o_reg_rdata == widen_id(VIC_ID_SPURIOUS) && !o_lr_ack)
		else $error("disabled group read did not return spurious");
	a_reserved_zero: assert property (rd_w && hit_control |=>
		(o_reg_rdata & ~VIC_CONTROL_MASK) == '0)
		else $error("reserved control bits read non-zero");

	// answers and strobes of the acknowledge path, one cycle after the read
	sequence s_read_alias;
		rd_w && hit_alias_ack;
	endsequence

	a_grp0_acked: assert property (s_read_ack ##0 hp_grp0 && grp0_en |=>
		o_lr_ack && o_lr_id == $past(i_hp_id)
		&& o_reg_rdata == widen_id($past(i_hp_id)))
		else $error("enabled group 0 read not acknowledged");
	a_grp0_spurious: assert property (s_read_ack ##0 hp_grp0 && !grp0_en |=>
		o_reg_rdata == widen_id(VIC_ID_SPURIOUS) && !o_lr_ack)
		else $error("disabled group 0 read did not return spurious");
	a_alias_grp1: assert property (s_read_alias ##0 hp_grp1 && grp1_en |=>
		o_lr_ack && o_reg_rdata == widen_id($past(i_hp_id)))
		else $error("aliased group 1 read not acknowledged");
	a_idle_spurious: assert property (s_read_ack ##0 !i_hp_valid |=>
		o_reg_rdata == widen_id(VIC_ID_SPURIOUS) && !o_lr_ack)
		else $error("read with nothing pending did not return spurious");
	a_grp1_normal: assert property (hp_grp1 && grp1_en |=>
		o_virtual_irq && !o_fast_interrupt_request)
		else $error("group 1 not presented as a normal request");
	// an empty list must never leave a stale request standing
	a_idle_quiet: assert property (!i_hp_valid |=>
		!o_virtual_irq && !o_fast_interrupt_request)
		else $error("request signalled with nothing pending");
	a_read_answer: assert property (rd_w |=> o_reg_rvalid)
		else $error("read not answered in the next cycle");
	a_write_silent: assert property (!rd_w |=> !o_reg_rvalid)
		else $error("read answer without a read");
	a_combined_eoi_id: assert property (s_eoi_combined |=> o_lr_id == $past(wr_id))
		else $error("combined end write updated the wrong entry");
	a_split_eoi_id: assert property (s_eoi_split |=> o_lr_id == $past(wr_id))
		else $error("split end write dropped the wrong entry");
	// reserved bits must never be stored, or they would read back later
	a_control_write: assert property (wr_w && hit_control |=>
		control_q == ($past(i_reg_wdata) & VIC_CONTROL_MASK))
		else $error("control write not stored with reserved bits cleared");
	a_grp0_point: assert property (!common_bp |=>
		o_grp0_binary_point == $past(i_binary_point))
		else $error("group 0 point not from main register");
endmodule

// file: test/vic_lr_model.sv
// Purpose: list register side model offering one pending virtual interrupt
// Assumes: the bench loads an entry; an acknowledge of that id consumes it
// Notes: id lines wander while nothing is pending, so a stale id never looks valid
module vic_lr_model
	import vic_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// entry load from the bench
	input wire logic i_load,
	input wire logic i_load_grp1,
	input wire logic [VIC_ID_W-1:0] i_load_id,
	// acknowledge from the design
	input wire logic i_lr_ack,
	input wire logic [VIC_ID_W-1:0] i_lr_id,
	// highest pending view
	output logic o_hp_valid,
	output logic o_hp_group1,
	output logic [VIC_ID_W-1:0] o_hp_id
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_hp_valid <= 1'b0;
			o_hp_group1 <= 1'b0;
			o_hp_id <= '0;
		end
		else if (i_load)
		begin
			o_hp_valid <= 1'b1;
			o_hp_group1 <= i_load_grp1;
			o_hp_id <= i_load_id;
		end
		else if (i_lr_ack && i_lr_id === o_hp_id)
			o_hp_valid <= 1'b0;
		else if (!o_hp_valid)
			o_hp_id <= ~o_hp_id;
	end
endmodule

// file: test/vic_control_tb.sv
// Purpose: self-checking bench for the virtual interface control block
// Assumes: one access at a time, answers sampled just after the answering edge
// Notes: control words after the first two fixed patterns, ids, groups and binary points are random from a fixed seed
`define CHK(nm, exp, got) \
	checks_done++; \
	if ((got) !== (exp)) \
	begin \
		$display("FAIL %s exp %h got %h", nm, exp, got); \
		error_cnt++; \
	end
module vic_control_tb
	import vic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic sel = 1'b0, wr = 1'b0, ld = 1'b0, lg = 1'b0, g = 1'b0, g0, g1;
	logic [12:0] addr = '0;
	logic [31:0] wd = '0, w, ctl;
	logic [9:0] lid = '0, id, id2;
	logic [10:0] e;
	logic [2:0] bp = '0, abp = '0, bp0, bp1;
	logic rvalid, hv, hg, virq, fast_req, drop, deact, lack, done;
	logic [31:0] rdata;
	logic [9:0] hid, lrid, did;
	int error_cnt = 0, checks_done = 0;
	vic_control vic_control_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_reg_sel(sel),
		.i_reg_write(wr), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rvalid(rvalid),
		.o_reg_rdata(rdata), .i_hp_valid(hv), .i_hp_group1(hg), .i_hp_id(hid),
		.i_binary_point(bp), .i_aliased_binary_point(abp), .o_grp0_binary_point(bp0),
		.o_grp1_binary_point(bp1), .o_virtual_irq(virq), .o_fast_interrupt_request(fast_req),
		.o_lr_drop(drop), .o_lr_deact(deact), .o_lr_ack(lack), .o_lr_id(lrid),
		.o_dist_done(done), .o_dist_id(did));
	vic_lr_model vic_lr_model_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_load(ld),
		.i_load_grp1(lg), .i_load_id(lid), .i_lr_ack(lack), .i_lr_id(lrid),
		.o_hp_valid(hv), .o_hp_group1(hg), .o_hp_id(hid));
	initial
	begin
		forever #4 i_clock = ~i_clock;
	end
	task automatic end_sim;
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one access; returns just after the edge that carries the answer
	task automatic acc(input logic wi, input logic [12:0] a, input logic [31:0] d);
		@(posedge i_clock);
		sel <= 1'b1;
		wr <= wi;
		addr <= a;
		wd <= d;
		@(posedge i_clock);
		sel <= 1'b0;
		#1;
	endtask
	task automatic load(input logic gi, input logic [9:0] i);
		@(posedge i_clock);
		ld <= 1'b1;
		lg <= gi;
		lid <= i;
		bp <= 3'($urandom);
		abp <= 3'($urandom);
		@(posedge i_clock);
		ld <= 1'b0;
	endtask
	function automatic logic [10:0] ack_exp(input logic [31:0] c, input logic gi,
		input logic [9:0] i, input logic alias_rd);
		if (!gi && c[0] && !alias_rd)
			return {1'b1, i};
		if (gi && c[1] && (c[2] || alias_rd))
			return {1'b1, i};
		if (gi && c[1] && !alias_rd)
			return {1'b0, 10'h03FE};
		return {1'b0, 10'h03FF};
	endfunction
	initial
	begin
		repeat (20000) @(posedge i_clock);
		error_cnt++;
		end_sim();
	end
	initial
	begin
		void'($urandom(69));
		repeat (12) @(posedge i_clock);
		i_arst_n <= 1'b1;
		acc(1'b0, 13'h0000, '0);
		`CHK("reset control", 32'h0000_0000, rdata)
		acc(1'b0, 13'h0100, '0);
		`CHK("unmapped rvalid", 1'b1, rvalid)
		`CHK("unmapped data", 32'h0000_0000, rdata)
		for (int n = 0; n < 60; n++)
		begin
			w = n == 0 ? 32'hFFFF_FFFF : (n == 1 ? 32'hFFFF_FDE0 : $urandom);
			if (n % 4 == 3)
				w[2] = 1'b0;
			ctl = w & 32'h0000_021F;
			id = 10'($urandom_range(1019));
			id2 = 10'($urandom_range(1019));
			g = 1'($urandom_range(1));
			acc(1'b1, 13'h0000, w);
			acc(1'b0, 13'h0000, '0);
			`CHK("control", ctl, rdata)
			load(g, id);
			repeat (2) @(posedge i_clock);
			#1;
			g0 = !g && ctl[0];
			g1 = g && ctl[1];
			`CHK("fast irq", g0 && ctl[3], fast_req)
			`CHK("virtual irq", (g0 && !ctl[3]) || g1, virq)
			`CHK("grp0 point", bp, bp0)
			`CHK("grp1 point", ctl[4] ? bp : abp, bp1)
			acc(1'b0, 13'h000C, '0);
			e = ack_exp(ctl, g, id, 1'b0);
			`CHK("ack id", {22'h0, e[9:0]}, rdata)
			`CHK("ack strobe", e[10], lack)
			load(g, id);
			acc(1'b0, 13'h0020, '0);
			e = ack_exp(ctl, g, id, 1'b1);
			`CHK("alias ack id", {22'h0, e[9:0]}, rdata)
			`CHK("alias ack strobe", e[10], lack)
			acc(1'b1, $urandom_range(1) ? 13'h0010 : 13'h0024, {22'h0, id});
			`CHK("end drop", 1'b1, drop)
			`CHK("end deact", !ctl[9], deact)
			`CHK("end done", !ctl[9], done)
			`CHK("end lr id", id, lrid)
			acc(1'b1, 13'h1000, {22'h0, id2});
			`CHK("dir deact", ctl[9], deact)
			`CHK("dir done", ctl[9], done)
			`CHK("dir drop", 1'b0, drop)
			`CHK("done id", ctl[9] ? id2 : id, did)
		end
		@(posedge i_clock);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_arst_n <= 1'b1;
		acc(1'b0, 13'h0000, '0);
		`CHK("control after reset", 32'h0000_0000, rdata)
		end_sim();
	end
endmodule
